// ### rtl/uart_am_map.svh
// Register indices, field positions and reset values of the
// address-match and baud-select block.
// Assumes word-wide AHB-Lite access, one register per aligned word.
`ifndef UART_AM_MAP_SVH
`define UART_AM_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL       10'h000
`define IDX_INT_STAT   10'h001
`define IDX_INT_MASK   10'h002
`define IDX_RX_DATA    10'h003
`define IDX_SLAVE_ADDR 10'h0A9
`define IDX_ADDR_MASK  10'h0B9

// Control word fields
`define CTRL_TX_T2     0
`define CTRL_RX_T2     1
`define CTRL_TX_GEN    2
`define CTRL_RX_GEN    3
`define CTRL_MP_EN     4
`define CTRL_MODE_LO   5
`define CTRL_MODE_HI   6

// Interrupt status and mask fields
`define INT_RX_FLAG    0
`define INT_ADDR_MISS  1

// Received data word: ninth bit sits above the byte
`define RXD_NINTH      8

// Reset values
`define RST_SLAVE_ADDR 8'h00
`define RST_ADDR_MASK  8'h00
`define RST_SEL        4'h0
`define RST_INT        2'h0
`define RST_BYTE       8'h00
`define RST_WORD       32'h0000_0000

`endif

// ### rtl/uart_am_pkg.sv
// Types shared by the address-match and baud-select block.
// Assumes the constants of uart_am_map.svh for all numbers.
`default_nettype none
package uart_am_pkg;

  // Serial port operating modes
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_UART8,
    MODE_UART9_FIXED,
    MODE_UART9
  } serial_mode_t;

  // Complete state of the top module
  typedef struct packed {
    logic         rd_pend;
    logic         wr_pend;
    logic [9:0]   idx;
    logic [31:0]  rdata;
    logic [7:0]   slave_address_reg;
    logic [7:0]   address_mask_reg;
    logic [3:0]   sel;
    logic         multiprocessor_enable;
    serial_mode_t mode;
    logic [1:0]   int_stat;
    logic [1:0]   int_mask;
    logic [7:0]   rx_byte;
    logic         rx_ninth;
    logic         tx_tick;
    logic         rx_tick;
  } state_t;

endpackage

`default_nettype wire

// ### rtl/uart_addr_match.sv
// Compares a received address byte with the given and broadcast
// addresses built from the slave address and mask registers.
// Assumes all inputs are stable in the cycle they are compared.
`timescale 1ns/1ps
`default_nettype none

module uart_addr_match (
  // Received byte
  input  wire logic [7:0] rx_byte,
  // Address registers
  input  wire logic [7:0] slave_address_reg,
  input  wire logic [7:0] address_mask_reg,
  // Match results
  output logic            given_hit,
  output logic            bcast_hit
);

  logic [7:0] bcast_addr;

  // Mask zeros are don't-care for the given address
  assign given_hit  = ((rx_byte ^ slave_address_reg) & address_mask_reg) == 8'h00;
  // Broadcast: OR of both, zeros don't-care, so ones must be ones
  assign bcast_addr = slave_address_reg | address_mask_reg;
  assign bcast_hit  = (rx_byte & bcast_addr) == bcast_addr;

endmodule

`default_nettype wire

// ### rtl/uart_addr_clk_sel.sv
// UART support block: automatic slave-address recognition and
// transmit/receive baud clock source selection, AHB-Lite registers.
// Assumes frame shifter, timers and rate generator run on clock.
//
// What this block does
// - Given address: slave address bits compared only where mask is one.
// - Broadcast address is address OR mask; zero positions are don't-care.
// - Reset clears address and mask, so every address is accepted.
// - Tx clock: generator if selected, else timer 2 or timer 1.
// - Rx clock chosen the same way, independent of transmit choice.
// - Per-direction source selection applies in variable-rate modes 1 and 3.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "uart_am_map.svh"

module uart_addr_clk_sel (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Baud tick sources, one-cycle enables
  input  wire logic        timer1_tick,
  input  wire logic        timer2_tick,
  input  wire logic        internal_rate_gen,
  input  wire logic        fixed_rate_tick,
  // Selected baud ticks
  output logic             tx_baud_tick,
  output logic             rx_baud_tick,
  // Frames from the shifter
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_bit9,
  // Receive flag and interrupt
  output logic             receive_flag,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////
  // Declarations

  uart_am_pkg::state_t st_ff;
  uart_am_pkg::state_t nxt_st;

  logic given_hit;
  logic bcast_hit;
  logic var_mode;
  logic addr_frame;
  logic accept;
  logic addr_ph;
  logic [1:0] clr_bits;

  ////////////////////////////////////////////////////////////////
  // Functions

  // Source pick shared by both directions
  function automatic logic pick_tick(
    input logic gen_sel,
    input logic t2_sel,
    input logic brg,
    input logic t2,
    input logic t1
  );
    if (gen_sel)
    begin
      pick_tick = brg;
    end
    else
    begin
      pick_tick = t2_sel ? t2 : t1;
    end
  endfunction

  // Read multiplexer; unmapped words read as zero
  function automatic logic [31:0] read_word(
    input uart_am_pkg::state_t s,
    input logic [9:0]          idx
  );
    read_word = `RST_WORD;
    unique case (idx)
      `IDX_CTRL:
      begin
        read_word[`CTRL_MODE_HI:`CTRL_MODE_LO] = s.mode;
        read_word[`CTRL_MP_EN]                 = s.multiprocessor_enable;
        read_word[`CTRL_RX_GEN:`CTRL_TX_T2]    = s.sel;
      end
      `IDX_INT_STAT:   read_word[1:0] = s.int_stat;
      `IDX_INT_MASK:   read_word[1:0] = s.int_mask;
      `IDX_RX_DATA:
      begin
        read_word[7:0]        = s.rx_byte;
        read_word[`RXD_NINTH] = s.rx_ninth;
      end
      `IDX_SLAVE_ADDR: read_word[7:0] = s.slave_address_reg;
      `IDX_ADDR_MASK:  read_word[7:0] = s.address_mask_reg;
      default:         read_word = `RST_WORD;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Address comparison

  uart_addr_match u_match (
    .rx_byte           (rx_data),
    .slave_address_reg (st_ff.slave_address_reg),
    .address_mask_reg  (st_ff.address_mask_reg),
    .given_hit         (given_hit),
    .bcast_hit         (bcast_hit)
  );

  // Frame qualification
  assign var_mode   = st_ff.mode == uart_am_pkg::MODE_UART8
                   || st_ff.mode == uart_am_pkg::MODE_UART9;
  // Ninth bit (stop bit in mode 1) marks an address frame
  assign addr_frame = st_ff.multiprocessor_enable && rx_bit9
                   && st_ff.mode != uart_am_pkg::MODE_SHIFT;
  assign accept     = !addr_frame || given_hit || bcast_hit;

  // Bus address phase accepted
  assign addr_ph = hsel && htrans[1] && hready;

  // Write-one-to-clear bits of this data phase
  assign clr_bits = (st_ff.wr_pend && st_ff.idx == `IDX_INT_STAT) ? hwdata[1:0] : 2'h0;

  ////////////////////////////////////////////////////////////////
  // Next state

  // Reads take one wait state so read data leave a flop
  always_comb
  begin
    nxt_st = st_ff;
    // Bus phases
    nxt_st.wr_pend = 1'b0;
    if (st_ff.rd_pend)
    begin
      nxt_st.rd_pend = 1'b0;
      nxt_st.rdata   = read_word(st_ff, st_ff.idx);
    end
    else if (addr_ph)
    begin
      nxt_st.idx     = haddr[11:2];
      nxt_st.wr_pend = hwrite;
      nxt_st.rd_pend = !hwrite;
    end
    // Register writes in the data phase
    if (st_ff.wr_pend)
    begin
      unique case (st_ff.idx)
        `IDX_CTRL:
        begin
          nxt_st.sel                   = hwdata[`CTRL_RX_GEN:`CTRL_TX_T2];
          nxt_st.multiprocessor_enable = hwdata[`CTRL_MP_EN];
          nxt_st.mode                  =
            uart_am_pkg::serial_mode_t'(hwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
        end
        `IDX_INT_MASK:   nxt_st.int_mask          = hwdata[1:0];
        `IDX_SLAVE_ADDR: nxt_st.slave_address_reg = hwdata[7:0];
        `IDX_ADDR_MASK:  nxt_st.address_mask_reg  = hwdata[7:0];
        default:         nxt_st.int_mask          = st_ff.int_mask;
      endcase
    end
    // Sticky events; a set in the clearing cycle wins
    nxt_st.int_stat = st_ff.int_stat & ~clr_bits;
    if (rx_valid && accept)
    begin
      nxt_st.int_stat[`INT_RX_FLAG] = 1'b1;
      nxt_st.rx_byte                = rx_data;
      nxt_st.rx_ninth               = rx_bit9;
    end
    if (rx_valid && !accept)
    begin
      nxt_st.int_stat[`INT_ADDR_MISS] = 1'b1;
    end
    // Baud tick steering; fixed-rate modes bypass the selection
    if (var_mode)
    begin
      nxt_st.tx_tick = pick_tick(st_ff.sel[`CTRL_TX_GEN], st_ff.sel[`CTRL_TX_T2],
                                 internal_rate_gen, timer2_tick, timer1_tick);
      nxt_st.rx_tick = pick_tick(st_ff.sel[`CTRL_RX_GEN], st_ff.sel[`CTRL_RX_T2],
                                 internal_rate_gen, timer2_tick, timer1_tick);
    end
    else
    begin
      nxt_st.tx_tick = fixed_rate_tick;
      nxt_st.rx_tick = fixed_rate_tick;
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register

  // Cleared address and mask make every address a hit
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff.rd_pend               <= 1'b0;
      st_ff.wr_pend               <= 1'b0;
      st_ff.idx                   <= 10'h000;
      st_ff.rdata                 <= `RST_WORD;
      st_ff.slave_address_reg     <= `RST_SLAVE_ADDR;
      st_ff.address_mask_reg      <= `RST_ADDR_MASK;
      st_ff.sel                   <= `RST_SEL;
      st_ff.multiprocessor_enable <= 1'b0;
      st_ff.mode                  <= uart_am_pkg::MODE_SHIFT;
      st_ff.int_stat              <= `RST_INT;
      st_ff.int_mask              <= `RST_INT;
      st_ff.rx_byte               <= `RST_BYTE;
      st_ff.rx_ninth              <= 1'b0;
      st_ff.tx_tick               <= 1'b0;
      st_ff.rx_tick               <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  // Bus answer; always OKAY
  assign hreadyout    = !st_ff.rd_pend;
  assign hresp        = 1'b0;
  assign hrdata       = st_ff.rdata;
  // Ticks lag their source by one cycle
  assign tx_baud_tick = st_ff.tx_tick;
  assign rx_baud_tick = st_ff.rx_tick;
  // Flag and level interrupt
  assign receive_flag = st_ff.int_stat[`INT_RX_FLAG];
  assign irq          = |(st_ff.int_stat & st_ff.int_mask);

  ////////////////////////////////////////////////////////////////
  // Assertions

  // Given-address hit on an address frame raises the flag
  AST_GIVEN_HIT: assert property (
    @(posedge clock) disable iff (rst)
    rx_valid && addr_frame
      && ((rx_data ^ st_ff.slave_address_reg) & st_ff.address_mask_reg) == 8'h00
    |=> receive_flag && st_ff.rx_byte == $past(rx_data))
  else $error("given address hit did not raise the flag");

  // All-ones byte always matches the broadcast address
  AST_BCAST_HIT: assert property (
    @(posedge clock) disable iff (rst)
    rx_valid && addr_frame && rx_data == 8'hFF
    |=> receive_flag
        && (!st_ff.int_stat[`INT_ADDR_MISS] || $past(st_ff.int_stat[`INT_ADDR_MISS])))
  else $error("broadcast byte was rejected");

  // Address registers and receive flag are clear after reset
  AST_RESET_CLEAR: assert property (
    @(posedge clock) disable iff (rst)
    $past(rst) |-> st_ff.slave_address_reg == 8'h00
               && st_ff.address_mask_reg == 8'h00 && !receive_flag)
  else $error("address registers not cleared by reset");

  // Transmit tick follows timer 2 when timer 2 is selected
  AST_TX_SELECT: assert property (
    @(posedge clock) disable iff (rst)
    var_mode && !st_ff.sel[`CTRL_TX_GEN] && st_ff.sel[`CTRL_TX_T2]
    |=> tx_baud_tick == $past(timer2_tick))
  else $error("transmit tick not from timer 2");

  // Receive tick follows the generator, whatever transmit picks
  AST_RX_SELECT: assert property (
    @(posedge clock) disable iff (rst)
    var_mode && st_ff.sel[`CTRL_RX_GEN]
    |=> rx_baud_tick == $past(internal_rate_gen))
  else $error("receive tick not from rate generator");

  // Fixed-rate modes ignore the selection bits
  AST_FIXED_MODE: assert property (
    @(posedge clock) disable iff (rst)
    (st_ff.mode == uart_am_pkg::MODE_SHIFT || st_ff.mode == uart_am_pkg::MODE_UART9_FIXED)
    |=> tx_baud_tick == $past(fixed_rate_tick) && rx_baud_tick == $past(fixed_rate_tick))
  else $error("fixed mode tick not from fixed source");

  // Unmatched address frame sets only the miss flag
  AST_MISS_IGNORED: assert property (
    @(posedge clock) disable iff (rst)
    rx_valid && addr_frame && !given_hit && !bcast_hit
    |=> !$rose(receive_flag) && st_ff.int_stat[`INT_ADDR_MISS])
  else $error("unmatched address frame raised the flag");

  // Read answer comes exactly two cycles after the address phase, one wait state
  AST_READ_WAIT: assert property (
    @(posedge clock) disable iff (rst)
    addr_ph && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
  else $error("read wait state is not one cycle");

  // Given hit equals a bitwise compare of the masked fields
  AST_GIVEN_FORM: assert property (
    @(posedge clock) disable iff (rst)
    given_hit == ((rx_data & st_ff.address_mask_reg)
                  == (st_ff.slave_address_reg & st_ff.address_mask_reg)))
  else $error("given address compare is wrong");

  // Broadcast hit needs a one wherever address or mask has one
  AST_BCAST_FORM: assert property (
    @(posedge clock) disable iff (rst)
    bcast_hit == ((~rx_data & (st_ff.slave_address_reg | st_ff.address_mask_reg)) == 8'h00))
  else $error("broadcast address compare is wrong");

  // Cleared registers make any frame a hit
  AST_ANY_ADDR: assert property (
    @(posedge clock) disable iff (rst)
    rx_valid && st_ff.slave_address_reg == 8'h00 && st_ff.address_mask_reg == 8'h00
    |=> receive_flag)
  else $error("cleared address registers rejected a frame");

  // Transmit tick follows the generator when it is selected
  AST_TX_GEN: assert property (
    @(posedge clock) disable iff (rst)
    var_mode && st_ff.sel[`CTRL_TX_GEN]
    |=> tx_baud_tick == $past(internal_rate_gen))
  else $error("transmit tick not from rate generator");

  // Receive tick follows its timer when the generator is off
  AST_RX_TIMER: assert property (
    @(posedge clock) disable iff (rst)
    var_mode && !st_ff.sel[`CTRL_RX_GEN]
    |=> rx_baud_tick == ($past(st_ff.sel[`CTRL_RX_T2]) ? $past(timer2_tick)
                                                      : $past(timer1_tick)))
  else $error("receive tick not from selected timer");

  // Data frames are always taken, address matching aside
  AST_DATA_FRAME: assert property (
    @(posedge clock) disable iff (rst)
    rx_valid && !addr_frame
    |=> receive_flag && st_ff.rx_byte == $past(rx_data))
  else $error("data frame was not taken");

  // A missed address frame leaves the data register alone
  AST_MISS_NO_LOAD: assert property (
    @(posedge clock) disable iff (rst)
    rx_valid && !accept
    |=> $stable(st_ff.rx_byte) && $stable(st_ff.rx_ninth))
  else $error("missed address frame loaded data");

endmodule

`default_nettype wire

// ### tb/uart_am_partner.sv
// Remote serial master handing frames to the address-match block.
// Assumes the frame input is sampled on the rising edge of clock.
`timescale 1ns/1ps
`default_nettype none

module uart_am_partner (
  // Clock
  input  wire logic  clock,
  // Frame output
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_bit9
);
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_bit9  = 1'b0;
  end

  ////////////////////////////////////////
  // One frame; lines invert after it so stale data never looks valid
  task automatic send(input logic [7:0] b, input logic n9);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data  <= b;
    rx_bit9  <= n9;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
    rx_bit9  <= ~n9;
  endtask
endmodule

`default_nettype wire

// ### tb/uart_addr_clk_sel_tb.sv
// Testbench of the address-match and baud-select block.
// Assumes the partner model and the register map header.
`timescale 1ns/1ps
`default_nettype none
`include "uart_am_map.svh"

module uart_addr_clk_sel_tb;
  logic        clock;
  logic        rst;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [3:0]  src;
  logic        tx_baud_tick;
  logic        rx_baud_tick;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_bit9;
  logic        receive_flag;
  logic        irq;
  logic [31:0] rd;
  int          bad_count;
  int          check_count;

  // Single slave: its ready is the bus ready
  uart_addr_clk_sel uart_addr_clk_sel_inst (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer1_tick(src[0]), .timer2_tick(src[1]), .internal_rate_gen(src[2]),
    .fixed_rate_tick(src[3]), .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_bit9(rx_bit9), .receive_flag(receive_flag), .irq(irq)
  );

  uart_am_partner uart_am_partner_inst (
    .clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_bit9(rx_bit9)
  );

  // 125 MHz clock
  initial
    clock = 1'b0;
  always #4 clock = ~clock;

  ////////////////////////////////////////
  // Verdict, the single exit point
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string m);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Bits reuse the word compare, unknowns still fail
  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_word({31'h0, got}, {31'h0, exp}, m);
  endtask

  // Bounded wait for ready sampled high at an edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t bus hang", $time);
      end_sim;
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clock);
    htrans <= 2'h2;
    haddr  <= {idx, 2'h0};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
    chk_bit(hresp, 1'b0, "hresp okay");
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input string m);
    bus(1'b0, idx, 32'h0);
    chk_word(rd, exp, m);
  endtask

  // Upper data bits set on purpose: only the byte may land
  task automatic cfg(input logic [31:0] ctl, input logic [7:0] a, input logic [7:0] m);
    bus(1'b1, `IDX_CTRL, ctl);
    bus(1'b1, `IDX_SLAVE_ADDR, {24'hFFFFFF, a});
    bus(1'b1, `IDX_ADDR_MASK, {24'hFFFFFF, m});
  endtask

  // Frame, then flag, status and, on a hit, data register, then clear
  task automatic frame(input logic [7:0] b, input logic n9, input logic hit);
    uart_am_partner_inst.send(b, n9);
    @(posedge clock);
    chk_bit(receive_flag, hit, "flag");
    rdchk(`IDX_INT_STAT, {30'h0, !hit, hit}, "status");
    if (hit)
      rdchk(`IDX_RX_DATA, {23'h0, n9, b}, "rx data");
    bus(1'b1, `IDX_INT_STAT, 32'h3);
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    rdchk(`IDX_SLAVE_ADDR, 32'h0, "addr rst");
    rdchk(`IDX_ADDR_MASK, 32'h0, "mask rst");
    bus(1'b1, `IDX_CTRL, 32'h70);
    frame(8'h5A, 1'b1, 1'b1);
  endtask

  // Mode 2 still matches addresses; shift mode takes every frame
  task automatic t_match;
    cfg(32'h70, 8'hF1, 8'hFA);
    rdchk(`IDX_SLAVE_ADDR, 32'hF1, "addr rw");
    frame(8'hF0, 1'b1, 1'b1);
    frame(8'hF3, 1'b1, 1'b0);
    frame(8'hFE, 1'b1, 1'b0);
    frame(8'hFB, 1'b1, 1'b1);
    frame(8'hFE, 1'b0, 1'b1);
    cfg(32'h30, 8'hF3, 8'hFD);
    frame(8'hFB, 1'b1, 1'b0);
    frame(8'hFF, 1'b1, 1'b1);
    cfg(32'h50, 8'hF3, 8'hFD);
    frame(8'hFB, 1'b1, 1'b0);
    bus(1'b1, `IDX_CTRL, 32'h10);
    frame(8'hFB, 1'b1, 1'b1);
    cfg(32'h30, 8'hF3, 8'hFD);
  endtask

  // Masked-in flag, masking, miss event, clear
  task automatic t_irq;
    bus(1'b1, `IDX_INT_MASK, 32'h1);
    uart_am_partner_inst.send(8'h12, 1'b0);
    @(posedge clock);
    chk_bit(irq, 1'b1, "irq on");
    bus(1'b1, `IDX_INT_MASK, 32'h2);
    @(posedge clock);
    chk_bit(irq, 1'b0, "irq masked");
    uart_am_partner_inst.send(8'hFE, 1'b1);
    @(posedge clock);
    chk_bit(irq, 1'b1, "irq miss");
    chk_bit(receive_flag, 1'b1, "flag sticky");
    bus(1'b1, `IDX_INT_STAT, 32'h3);
    @(posedge clock);
    chk_bit(irq, 1'b0, "irq clear");
    chk_bit(receive_flag, 1'b0, "flag clear");
    bus(1'b1, 10'h050, 32'hFFFFFFFF);
    rdchk(10'h050, 32'h0, "unmapped");
  endtask

  // Reset in mid-run after registers and flag were set
  task automatic t_rerst;
    uart_am_partner_inst.send(8'h3C, 1'b0);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk_bit(receive_flag, 1'b0, "flag rerst");
    chk_bit(irq, 1'b0, "irq rerst");
    rdchk(`IDX_SLAVE_ADDR, 32'h0, "addr rerst");
    rdchk(`IDX_ADDR_MASK, 32'h0, "mask rerst");
    rdchk(`IDX_CTRL, 32'h0, "ctrl rerst");
    rdchk(`IDX_INT_MASK, 32'h0, "imask rerst");
    rdchk(`IDX_RX_DATA, 32'h0, "rxdata rerst");
    bus(1'b1, `IDX_CTRL, 32'h70);
    frame(8'hA5, 1'b1, 1'b1);
  endtask

  // Every mode, select word and source pulse
  task automatic t_baud;
    logic [3:0] s;
    logic       vr;
    logic       ex_tx;
    logic       ex_rx;
    for (int m = 0; m < 4; m++)
      for (int sel = 0; sel < 16; sel++)
      begin
        s = sel[3:0];
        vr = (m == 1 || m == 3);
        bus(1'b1, `IDX_CTRL, {25'h0, m[1:0], 1'b0, s});
        for (int k = 0; k < 4; k++)
        begin
          @(posedge clock);
          src <= 4'h1 << k;
          @(posedge clock);
          src <= 4'h0;
          @(posedge clock);
          ex_tx = vr ? (s[2] ? k == 2 : s[0] ? k == 1 : k == 0) : k == 3;
          ex_rx = vr ? (s[3] ? k == 2 : s[1] ? k == 1 : k == 0) : k == 3;
          chk_bit(tx_baud_tick, ex_tx, "tx tick");
          chk_bit(rx_baud_tick, ex_rx, "rx tick");
        end
      end
  endtask

  ////////////////////////////////////////
  initial
  begin
    bad_count = 0;
    check_count = 0;
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    src = 4'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_match;
    t_irq;
    t_rerst;
    t_baud;
    end_sim;
  end
endmodule

`default_nettype wire
